/* src/csc_pkg.sv */
// package: register offsets, field positions and reset values for the card status-change block
package csf_pkg;
  localparam logic [11:0] CSF_FLAGS_OFS_A  = 12'h804;
  localparam logic [11:0] CSF_CONFIG_OFS_A = 12'h805;
  localparam logic [11:0] CSF_FLAGS_OFS_B  = 12'h844;
  localparam logic [11:0] CSF_CONFIG_OFS_B = 12'h845;
  localparam logic [7:0]  CSF_FLAGS_RESET  = 8'h00;
  localparam logic [7:0]  CSF_CONFIG_RESET = 8'h00;
  localparam int          CSF_BIT_DETECT   = 3;
  localparam int          CSF_BIT_READY    = 2;
  localparam int          CSF_BIT_BATLOW   = 1;
  localparam int          CSF_BIT_BATTERY_DEAD_FLAG  = 0;
  localparam int          CSF_GLOBAL_W1C   = 2;
  localparam logic [3:0]  CSF_FLAG_MASK    = 4'hF;
endpackage : csf_pkg

/* src/csc_socket_flags.sv */
// card status-change flags and interrupt configuration for two sockets
`timescale 1ns/1ps
`default_nettype none
module csf_socket_flags
  import csf_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_read_i,
  input  wire logic        reg_write_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [1:0]  flag_clear_w1c_i,
  input  wire logic [1:0]  io_card_i,
  input  wire logic [1:0]  ring_mode_i,
  input  wire logic [1:0]  card_detect_one_i,
  input  wire logic [1:0]  card_detect_two_i,
  input  wire logic [1:0]  card_ready_i,
  input  wire logic [1:0]  battery_low_i,
  input  wire logic [1:0]  battery_dead_i,
  input  wire logic [1:0]  card_status_signal_i,
  input  wire logic [1:0]  ring_signal_i,
  output logic      [1:0]  card_status_event_o
);
  localparam int NS = 2;
  localparam int SW = 7;

  // slot of each card pin inside one socket's synchronised word
  localparam int PIN_DETECT_ONE = 0;
  localparam int PIN_DETECT_TWO = 1;
  localparam int PIN_READY      = 2;
  localparam int PIN_BATLOW     = 3;
  localparam int PIN_BATTERY_DEAD_FLAG    = 4;
  localparam int PIN_STATUS     = 5;
  localparam int PIN_RING       = 6;

  logic [NS*SW-1:0] sync_in;
  logic [NS*SW-1:0] sync_q;
  logic [NS*SW-1:0] prev_q;
  logic [3:0]       flags     [NS];
  logic [7:0]       config_r  [NS];
  logic [3:0]       next_flags[NS];
  logic [3:0]       events    [NS];
  logic [3:0]       visible   [NS];
  logic [7:0]       next_rdata;

  function automatic logic [11:0] flags_ofs(input int s);
    return (s == 0) ? CSF_FLAGS_OFS_A : CSF_FLAGS_OFS_B;
  endfunction

  function automatic logic [11:0] config_ofs(input int s);
    return (s == 0) ? CSF_CONFIG_OFS_A : CSF_CONFIG_OFS_B;
  endfunction

  // raw source conditions of one socket, before the enables are applied
  function automatic logic [3:0] source_events(input logic [SW-1:0] c,
                                               input logic [SW-1:0] p,
                                               input logic          io);
    logic [3:0] e;
    e = 4'h0;
    e[CSF_BIT_DETECT]  = (c[PIN_DETECT_ONE] ^ p[PIN_DETECT_ONE]) |
                         (c[PIN_DETECT_TWO] ^ p[PIN_DETECT_TWO]);
    e[CSF_BIT_READY]   = !io && c[PIN_READY] && !p[PIN_READY];
    // level source: while still asserted it stays set through a clear, since the set wins in that cycle
    e[CSF_BIT_BATLOW]  = !io && c[PIN_BATLOW];
    // battery dead on memory cards, status-change on I/O cards
    e[CSF_BIT_BATTERY_DEAD_FLAG] = io ? c[PIN_STATUS] : c[PIN_BATTERY_DEAD_FLAG];
    return e;
  endfunction

  // bits that one bus cycle clears in one socket
  function automatic logic [3:0] clear_mask(input logic       hit,
                                            input logic       rd,
                                            input logic       wr,
                                            input logic       w1c,
                                            input logic [3:0] wdata);
    logic [3:0] m;
    m = 4'h0;
    if (hit && wr && w1c) begin
      m = wdata;
    end
    if (hit && rd && !w1c) begin
      m = CSF_FLAG_MASK;
    end
    return m;
  endfunction

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      sync_in[s*SW +: SW] = {ring_signal_i[s], card_status_signal_i[s], battery_dead_i[s],
                             battery_low_i[s], card_ready_i[s], card_detect_two_i[s],
                             card_detect_one_i[s]};
    end
  end

  // every card pin is asynchronous, so all of them pass two flops
  csf_sync #(.W(NS*SW)) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   (sync_in),
    .sync_o    (sync_q)
  );

  // previous synchronised values, for edge detection
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_q;
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      events[s] = source_events(sync_q[s*SW +: SW], prev_q[s*SW +: SW], io_card_i[s]);
      events[s] = events[s] & config_r[s][3:0];
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      logic [3:0] clr;
      clr = clear_mask(reg_addr_i == flags_ofs(s), reg_read_i, reg_write_i,
                       flag_clear_w1c_i[s], reg_wdata_i[3:0]);
      // set wins over a clear in the same cycle so no event is lost
      next_flags[s] = (flags[s] & ~clr) | events[s];
      // a disabled source reads 0 and cannot hold a stale flag
      next_flags[s] = next_flags[s] & config_r[s][3:0];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < NS; s++) begin
        flags[s] <= CSF_FLAGS_RESET[3:0];
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        flags[s] <= next_flags[s];
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < NS; s++) begin
        config_r[s] <= CSF_CONFIG_RESET;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        if (reg_write_i && reg_addr_i == config_ofs(s)) begin
          config_r[s] <= reg_wdata_i;
        end
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      visible[s] = flags[s];
      // ring mode shows the live ring level, gated by the same enable
      if (ring_mode_i[s]) begin
        visible[s][CSF_BIT_BATTERY_DEAD_FLAG] = sync_q[s*SW+PIN_RING] &
                                      config_r[s][CSF_BIT_BATTERY_DEAD_FLAG];
      end
    end
  end

  // read data mux; unmapped reads answer zero, other cycles keep the last answer
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_read_i) begin
      next_rdata = 8'h00;
      for (int s = 0; s < NS; s++) begin
        if (reg_addr_i == flags_ofs(s)) begin
          next_rdata = {4'h0, visible[s]};
        end
        if (reg_addr_i == config_ofs(s)) begin
          next_rdata = config_r[s];
        end
      end
    end
  end

  // read data registered; reads take effect on the request cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // taken from the next flags so the request carries no extra cycle of lag
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      card_status_event_o <= 2'h0;
    end else begin
      for (int s = 0; s < NS; s++) begin
        card_status_event_o[s] <= |next_flags[s];
      end
    end
  end
endmodule // csf_socket_flags
`default_nettype wire

/* src/csc_sync.sv */
// two-flop synchroniser for socket-side levels
`timescale 1ns/1ps
`default_nettype none
module csf_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // meta feeds only the second flop
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // csf_sync
`default_nettype wire

/* verification/csc_card_model.sv */
// card model: socket-side pins of both cards
`timescale 1ns/1ps
`default_nettype none
module csf_card_model (
  input  wire logic        clock_i,
  input  wire logic [13:0] want_i,
  output logic      [13:0] pins_o
);
  // pins move on the edge after the bench asks, so never race its falling-edge drive
  always_ff @(posedge clock_i) pins_o <= want_i;
endmodule // csf_card_model
`default_nettype wire

/* verification/csc_socket_flags_assertions.sv */
// checker: port assertions for the card status-change block
`timescale 1ns/1ps
`default_nettype none
module csf_flags_chk
  import csf_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic        reg_read_i,
  input wire logic        reg_write_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [1:0]  flag_clear_w1c_i,
  input wire logic [1:0]  ring_mode_i,
  input wire logic [1:0]  card_detect_one_i,
  input wire logic [1:0]  ring_signal_i,
  input wire logic [1:0]  card_status_event_o
);
  logic [7:0] cfg_a;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // enables rebuilt from bus writes, so masking is judged without peeking inside
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) cfg_a <= 8'h00;
    else if (reg_write_i && reg_addr_i == CSF_CONFIG_OFS_A) cfg_a <= reg_wdata_i;
  end
  sequence s_rd_a; reg_read_i && reg_addr_i == CSF_FLAGS_OFS_A; endsequence
  sequence s_rd_b; reg_read_i && reg_addr_i == CSF_FLAGS_OFS_B; endsequence
  sequence s_quiet; !reg_read_i && !reg_write_i; endsequence
  sequence s_still; ring_mode_i[0] && $stable(ring_signal_i[0]); endsequence
  property p_upper_zero; (s_rd_a or s_rd_b) |=> reg_rdata_o[7:4] == 4'h0; endproperty
  property p_irq_a; s_rd_a ##0 !ring_mode_i[0] |=>
    (reg_rdata_o[3:0] != 4'h0) == $past(card_status_event_o[0]); endproperty
  property p_irq_b; s_rd_b ##0 !ring_mode_i[1] |=>
    (reg_rdata_o[3:0] != 4'h0) == $past(card_status_event_o[1]); endproperty
  property p_cfg_back; reg_read_i && reg_addr_i == CSF_CONFIG_OFS_A |=>
    reg_rdata_o == $past(cfg_a); endproperty
  property p_masked; s_rd_a |=> (reg_rdata_o[3:0] & ~$past(cfg_a[3:0])) == 4'h0; endproperty
  property p_w1c_hold; s_rd_a ##0 (flag_clear_w1c_i[0] && !reg_write_i && card_status_event_o[0])
    |=> card_status_event_o[0]; endproperty
  property p_detect; ($changed(card_detect_one_i[0]) && cfg_a[3]) ##1 s_quiet[*3]
    |-> card_status_event_o[0]; endproperty
  property p_ring; s_still[*3] ##0 s_rd_a |=>
    reg_rdata_o[0] == ($past(ring_signal_i[0]) & $past(cfg_a[0])); endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper status bits set");
  a_irq_a: assert property (p_irq_a) else $error("socket A request disagrees");
  a_irq_b: assert property (p_irq_b) else $error("socket B request disagrees");
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  a_masked: assert property (p_masked) else $error("disabled flag reads 1");
  a_w1c_hold: assert property (p_w1c_hold) else $error("read cleared in w1c mode");
  a_detect: assert property (p_detect) else $error("detect change not flagged");
  a_ring: assert property (p_ring) else $error("ring bit wrong");
endmodule // csf_flags_chk
bind csf_socket_flags csf_flags_chk csf_flags_chk_inst (.clock_i, .reset_n_i, .reg_addr_i,
  .reg_read_i, .reg_write_i, .reg_wdata_i, .reg_rdata_o, .flag_clear_w1c_i, .ring_mode_i,
  .card_detect_one_i, .ring_signal_i, .card_status_event_o);
`default_nettype wire

/* verification/csc_socket_flags_tb.sv */
// testbench: card status-change block against a flag model
`timescale 1ns/1ps
`default_nettype none
module csf_socket_flags_tb
  import csf_pkg::*;
();
  logic        clock_i = 1'b0, reset_n_i = 1'b0, reg_read_i = 1'b0, reg_write_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
  logic [1:0]  w1c = 2'h0, io = 2'h0, ring = 2'h0, card_status_event_o;
  logic [13:0] want = 14'h0000, pins;
  logic [31:0] seed = 32'h00003521;
  int          num_errors = 0, n_tests = 0, i, j, flg[2] = '{0, 0}, cfg[2] = '{0, 0};
  always #5 clock_i = ~clock_i;
  csf_card_model csf_card_model_inst (.clock_i, .want_i(want), .pins_o(pins));
  csf_socket_flags csf_socket_flags_inst (.clock_i, .reset_n_i, .reg_addr_i, .reg_read_i,
    .reg_write_i, .reg_wdata_i, .reg_rdata_o, .flag_clear_w1c_i(w1c), .io_card_i(io),
    .ring_mode_i(ring), .card_detect_one_i(pins[1:0]), .card_detect_two_i(pins[3:2]),
    .card_ready_i(pins[5:4]), .battery_low_i(pins[7:6]), .battery_dead_i(pins[9:8]),
    .card_status_signal_i(pins[11:10]), .ring_signal_i(pins[13:12]), .card_status_event_o);
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic rd, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_read_i = rd;
    reg_write_i = !rd;
    reg_wdata_i = d;
    @(negedge clock_i);
    reg_read_i = 1'b0;
    reg_write_i = 1'b0;
  endtask
  task automatic rf(input int s);
    bus(s ? CSF_FLAGS_OFS_B : CSF_FLAGS_OFS_A, 1'b1, 8'h00);
    chk(reg_rdata_o, 8'(flg[s]));
    if (!w1c[s]) flg[s] = 0;
  endtask
  task automatic wc(input int s, input logic [7:0] d);
    bus(s ? CSF_CONFIG_OFS_B : CSF_CONFIG_OFS_A, 1'b0, d);
    cfg[s] = d;
    flg[s] &= d;
  endtask
  // the card pin reaches the flag four rising edges later, so four falling edges are waited
  task automatic pin(input int k, input int s, input logic v, input int b);
    @(negedge clock_i);
    want[k * 2 + s] = v;
    flg[s] |= b & cfg[s] & 15;
    repeat (4) @(negedge clock_i);
    for (i = 0; i < 8 && card_status_event_o[s] !== (flg[s] != 0); i++) @(negedge clock_i);
    if (i == 8) begin
      num_errors++;
      results();
    end
    chk(8'(card_status_event_o[s]), 8'(flg[s] != 0));
  endtask
  initial begin
    repeat (3) @(negedge clock_i);
    reset_n_i = 1'b1;
    for (j = 0; j < 5; j++) begin
      bus(j < 4 ? 12'h804 + 12'(j / 2 * 64 + j % 2) : 12'h806, 1'b1, 8'h00);
      chk(reg_rdata_o, 8'h00);
    end
    seed = xorshift(seed);
    wc(1, seed[7:0]);
    bus(CSF_CONFIG_OFS_B, 1'b1, 8'h00);
    chk(reg_rdata_o, 8'(cfg[1]));
    $display("test 1 done");
    pin(0, 0, 1'b1, 8);
    rf(0);
    wc(0, 8'h0F);
    pin(1, 0, 1'b1, 8);
    rf(0);
    rf(0);
    pin(0, 0, 1'b0, 8);
    rf(0);
    w1c[0] = 1'b1;
    pin(2, 0, 1'b1, 4);
    rf(0);
    rf(0);
    bus(CSF_FLAGS_OFS_A, 1'b0, 8'hF4);
    flg[0] &= ~4;
    rf(0);
    $display("test 2 done");
    pin(3, 0, 1'b1, 2);
    pin(3, 0, 1'b0, 0);
    w1c[0] = 1'b0;
    rf(0);
    io[0] = 1'b1;
    pin(2, 0, 1'b0, 0);
    pin(2, 0, 1'b1, 0);
    pin(3, 0, 1'b1, 0);
    pin(5, 0, 1'b1, 1);
    pin(5, 0, 1'b0, 0);
    rf(0);
    rf(0);
    $display("test 3 done");
    ring[0] = 1'b1;
    for (j = 1; j >= 0; j--) begin
      pin(6, 0, j[0], 0);
      bus(CSF_FLAGS_OFS_A, 1'b1, 8'h00);
      chk(reg_rdata_o, 8'(j));
    end
    wc(1, 8'h08);
    pin(0, 1, 1'b1, 8);
    rf(1);
    $display("test 4 done");
    results();
  end
endmodule // csf_socket_flags_tb
`default_nettype wire
